// >>> logic/uid_select.sv
// card-side identifier usage configuration and activation logic
`timescale 1ns/1ps
`include "uid_select_map.svh"
module uid_select import uid_select_pkg::*; (
    // clock and reset
    input  wire logic        sys_clk,
    input  wire logic        rst_n,
    // decoded reader frames
    input  wire rx_t         rx,
    // identity sources
    input  wire logic        variant_seven,
    input  wire logic [55:0] uid_blk0,
    input  wire logic [31:0] rnd_id,
    input  wire logic        auth_sec0_ok,
    // nonvolatile configuration cell
    input  wire usage_t      nv_setting,
    input  wire logic        nv_locked,
    output logic             nv_we,
    output usage_t           nv_wdata,
    // card answers
    output resp_t            resp,
    output logic [31:0]      auth_uid,
    output logic             card_active
);
    typedef enum {ST_IDLE, ST_READY1, ST_READY2, ST_ACTIVE, ST_HALT} st_t;
    localparam logic [9:0] FDT_LAST = 10'(`FDT_CYC - 1);

    st_t         st_r, st_nxt;
    usage_t      stored_r, stored_nxt;
    usage_t      act_r, act_nxt;
    logic        locked_r, locked_nxt;
    logic        init_r, init_nxt;
    seq_t        seq_r, seq_nxt;
    logic        pend_r, pend_nxt;
    logic [3:0]  pend_ans_r, pend_ans_nxt;
    logic [9:0]  fdt_r, fdt_nxt;
    resp_t       resp_r, resp_nxt;
    logic [31:0] auid_r, auid_nxt;
    logic        we_r, we_nxt;
    usage_t      wd_r, wd_nxt;
    logic        active_r, active_nxt;

    // ------------------------------------------------------------
    // identifier views
    // ------------------------------------------------------------
    logic [31:0] uid_lo, uid_hi, non_unique_identifier, cl1_word;
    logic        double_cl, type_ok;
    usage_t      type_dec;
    assign uid_lo = uid_blk0[31:0];                          // [R1]
    assign uid_hi = uid_blk0[55:24];
    // derived identifier: fold of all seven bytes, not unique
    assign non_unique_identifier = uid_lo ^ {8'h00, uid_blk0[55:32]};
    assign double_cl = variant_seven &&
        (act_r == USAGE_DOUBLE_SIZE ||
         act_r == USAGE_DOUBLE_SIZE_SHORTCUT);               // [R19]

    always_comb begin
        if (!variant_seven) begin
            cl1_word = uid_lo;                               // [R20]
        end else begin
            unique case (act_r)
                USAGE_RANDOM_SINGLE:  cl1_word = rnd_id;     // [R17]
                USAGE_DERIVED_SINGLE: cl1_word = non_unique_identifier;       // [R17]
                default: cl1_word = {uid_blk0[23:0], `CASCADE_TAG};
            endcase
        end
    end

    always_comb begin
        type_ok = 1'b1;
        unique case (rx.arg)                                 // [R4]
            `TYPE_DOUBLE:   type_dec = USAGE_DOUBLE_SIZE;
            `TYPE_SHORTCUT: type_dec = USAGE_DOUBLE_SIZE_SHORTCUT;
            `TYPE_RANDOM:   type_dec = USAGE_RANDOM_SINGLE;
            `TYPE_DERIVED:  type_dec = USAGE_DERIVED_SINGLE;
            default: begin
                type_dec = stored_r;
                type_ok  = 1'b0;                             // [R22]
            end
        endcase
    end

    // ------------------------------------------------------------
    // frame interpreter
    // ------------------------------------------------------------
    logic take, is_sel1, is_sel2, halt_cmd, perso_ok;
    // frames dropped while an answer is owed; reader must not overlap
    assign take     = rx.valid && rx.crc_ok && !pend_r;
    assign is_sel1  = rx.cmd == `CMD_SEL_ONE;
    assign is_sel2  = rx.cmd == `CMD_SEL_TWO;
    assign halt_cmd = take && rx.cmd == `CMD_HALT;
    assign perso_ok = variant_seven && auth_sec0_ok &&       // [R5]
                      !locked_r && type_ok;                  // [R7] [R22]

    always_comb begin
        st_nxt       = st_r;
        stored_nxt   = stored_r;
        act_nxt      = act_r;
        locked_nxt   = locked_r;
        init_nxt     = 1'b1;
        seq_nxt      = seq_r;
        pend_nxt     = pend_r;
        pend_ans_nxt = pend_ans_r;
        fdt_nxt      = fdt_r;
        resp_nxt     = '0;
        auid_nxt     = auid_r;
        we_nxt       = 1'b0;
        wd_nxt       = wd_r;
        // stored copy caught once after reset release
        if (!init_r) begin
            stored_nxt = nv_setting;
            act_nxt    = nv_setting;                         // [R9]
            locked_nxt = nv_locked;
        end
        if (pend_r) begin
            if (fdt_r == FDT_LAST) begin
                pend_nxt      = 1'b0;
                resp_nxt.valid = 1'b1;
                resp_nxt.kind  = RESP_ACKNAK;
                resp_nxt.data  = {28'h0, pend_ans_r};        // [R10]
            end else begin
                fdt_nxt = fdt_r + 10'd1;
            end
        end
        if (take && init_r) begin
            unique case (st_r)
                ST_IDLE, ST_HALT: begin
                    if (rx.cmd == `CMD_WAKE ||
                        (rx.cmd == `CMD_REQ && st_r == ST_IDLE)) begin
                        st_nxt         = ST_READY1;
                        resp_nxt.valid = 1'b1;
                        resp_nxt.kind  = RESP_ATQA;
                        resp_nxt.data  = variant_seven ?     // [R11]
                            {16'h0, `ATQA_SEVEN} : {16'h0, `ATQA_FOUR};
                    end
                end
                ST_READY1: begin
                    if (is_sel1 && rx.arg == `ARG_ANTICOL) begin
                        resp_nxt.valid = 1'b1;
                        resp_nxt.kind  = RESP_UID;
                        resp_nxt.data  = cl1_word;
                    end else if (is_sel1 && rx.arg == `ARG_SELECT &&
                                 rx.sel_uid == cl1_word) begin
                        resp_nxt.valid = 1'b1;
                        resp_nxt.kind  = RESP_SAK;
                        if (double_cl) begin
                            st_nxt        = ST_READY2;       // [R13]
                            resp_nxt.data = {24'h0, `SAK_MORE};
                        end else begin
                            st_nxt        = ST_ACTIVE;       // [R19]
                            seq_nxt       = SEQ_THREE;       // [R16]
                            auid_nxt      = cl1_word;        // [R18] [R20]
                            resp_nxt.data = {24'h0, `SAK_DONE};
                        end
                    end else begin
                        st_nxt = ST_IDLE;
                    end
                end
                ST_READY2: begin
                    if (is_sel2 && rx.arg == `ARG_ANTICOL) begin
                        resp_nxt.valid = 1'b1;
                        resp_nxt.kind  = RESP_UID;
                        resp_nxt.data  = uid_hi;
                    end else if (is_sel2 && rx.arg == `ARG_SELECT &&
                                 rx.sel_uid == uid_hi) begin
                        st_nxt         = ST_ACTIVE;          // [R13]
                        seq_nxt        = SEQ_ONE;
                        auid_nxt       = uid_hi;             // [R18]
                        resp_nxt.valid = 1'b1;
                        resp_nxt.kind  = RESP_SAK;
                        resp_nxt.data  = {24'h0, `SAK_DONE}; // [R12]
                    end else if (rx.cmd == `CMD_READ &&
                                 rx.arg == 8'h00 &&
                                 act_r == USAGE_DOUBLE_SIZE_SHORTCUT) begin
                        st_nxt           = ST_ACTIVE;        // [R16]
                        seq_nxt          = SEQ_TWO;
                        auid_nxt         = cl1_word;         // [R18]
                        resp_nxt.valid   = 1'b1;
                        resp_nxt.kind    = RESP_BLOCK0;      // [R14]
                        resp_nxt.encrypt = 1'b0;
                    end else begin
                        st_nxt = ST_IDLE;
                    end
                end
                ST_ACTIVE: begin
                    if (rx.cmd == `CMD_HALT) begin
                        st_nxt  = ST_HALT;
                        act_nxt = stored_r;                  // [R9]
                    end else if (rx.cmd == `CMD_READ && rx.arg == 8'h00) begin
                        resp_nxt.valid = 1'b1;
                        if (auth_sec0_ok) begin
                            resp_nxt.kind    = RESP_BLOCK0;  // [R15]
                            resp_nxt.encrypt = 1'b1;
                        end else begin
                            resp_nxt.kind = RESP_ACKNAK;
                            resp_nxt.data = {28'h0, `ANS_NAK};
                        end
                    end else if (rx.cmd == `CMD_PERSO) begin // [R3]
                        pend_nxt = 1'b1;
                        fdt_nxt  = 10'd0;
                        if (perso_ok) begin
                            stored_nxt   = type_dec;
                            locked_nxt   = 1'b1;             // [R6]
                            we_nxt       = 1'b1;
                            wd_nxt       = type_dec;
                            pend_ans_nxt = `ANS_ACK;         // [R8]
                        end else begin
                            pend_ans_nxt = `ANS_NAK;         // [R7] [R8]
                        end
                    end
                end
            endcase
        end
        active_nxt = (st_nxt == ST_ACTIVE);
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            st_r       <= ST_IDLE;
            stored_r   <= USAGE_DOUBLE_SIZE_SHORTCUT;        // [R2]
            act_r      <= USAGE_DOUBLE_SIZE_SHORTCUT;
            locked_r   <= 1'b0;
            init_r     <= 1'b0;
            seq_r      <= SEQ_ONE;
            pend_r     <= 1'b0;
            pend_ans_r <= `ANS_NAK;
            fdt_r      <= 10'd0;
            resp_r     <= '0;
            auid_r     <= 32'h0;
            we_r       <= 1'b0;
            wd_r       <= USAGE_DOUBLE_SIZE_SHORTCUT;
            active_r   <= 1'b0;
        end else begin
            st_r       <= st_nxt;
            stored_r   <= stored_nxt;
            act_r      <= act_nxt;
            locked_r   <= locked_nxt;
            init_r     <= init_nxt;
            seq_r      <= seq_nxt;
            pend_r     <= pend_nxt;
            pend_ans_r <= pend_ans_nxt;
            fdt_r      <= fdt_nxt;
            resp_r     <= resp_nxt;
            auid_r     <= auid_nxt;
            we_r       <= we_nxt;
            wd_r       <= wd_nxt;
            active_r   <= active_nxt;
        end
    end

    assign resp        = resp_r;
    assign auth_uid    = auid_r;
    // registered so the output never glitches on state decode
    assign card_active = active_r;
    assign nv_we       = we_r;
    assign nv_wdata    = wd_r;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    logic [10:0] gap_r, gap_nxt;
    // saturates so a long idle spell cannot wrap into a short gap
    always_comb begin
        gap_nxt = gap_r;
        if (rx.valid) begin
            gap_nxt = 11'd0;
        end else if (gap_r != 11'h7ff) begin
            gap_nxt = gap_r + 11'd1;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            gap_r <= 11'd0;
        end else begin
            gap_r <= gap_nxt;
        end
    end

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_n);

    AST_FDT_MIN: assert property ( // [R10]
        resp_r.valid && resp_r.kind == RESP_ACKNAK &&
        resp_r.data[3:0] == `ANS_ACK |-> gap_r >= 11'(`FDT_CYC))
        else $error("acknowledge sent before frame delay");
    AST_LOCK_STICKY: assert property ( // [R6]
        locked_r && init_r |=> locked_r)
        else $error("lock released");
    AST_LOCKED_HOLD: assert property ( // [R7]
        locked_r && init_r |=> $stable(stored_r) && !we_r)
        else $error("setting changed while locked");
    AST_PERSO_LOCKS: assert property ( // [R6]
        we_r |-> locked_r && stored_r == wd_r)
        else $error("write without lock");
    AST_ACK_CODE: assert property ( // [R8]
        we_r |-> pend_r && fdt_r == 10'd0 && pend_ans_r == `ANS_ACK)
        else $error("accepted write not queued with Ah");
    AST_ACK_SENT: assert property ( // [R8]
        pend_r && fdt_r == FDT_LAST |=> resp_r.valid &&
        resp_r.kind == RESP_ACKNAK && resp_r.data[3:0] == pend_ans_r)
        else $error("queued answer not sent after frame delay");
    AST_AUTH_WRITE: assert property ( // [R5]
        we_r |-> variant_seven && $past(auth_sec0_ok))
        else $error("write without sector 0 authentication");
    AST_RANDOM_ID: assert property ( // [R17]
        resp_r.valid && resp_r.kind == RESP_UID && variant_seven &&
        act_r == USAGE_RANDOM_SINGLE |-> resp_r.data == rnd_id)
        else $error("random identifier not returned");
    AST_DEFER: assert property ( // [R9]
        init_r && $past(init_r) && $changed(act_r) |->
        $past(halt_cmd) && $past(st_r) == ST_ACTIVE)
        else $error("setting applied without unselect");
    AST_ATQA: assert property ( // [R11]
        resp_r.valid && resp_r.kind == RESP_ATQA |->
        resp_r.data[15:0] == (variant_seven ? `ATQA_SEVEN : `ATQA_FOUR))
        else $error("request answer wrong");
    AST_SAK_DONE: assert property ( // [R12]
        resp_r.valid && resp_r.kind == RESP_SAK &&
        resp_r.data[7:0] == `SAK_DONE |-> st_r == ST_ACTIVE)
        else $error("select done but not active");
    AST_FOUR_LEVEL: assert property ( // [R19]
        !variant_seven |-> st_r != ST_READY2)
        else $error("four-byte card entered level two");
    AST_PLAIN_SEQ2: assert property ( // [R14]
        resp_r.valid && resp_r.kind == RESP_BLOCK0 && !resp_r.encrypt
        |-> seq_r == SEQ_TWO && $past(st_r) == ST_READY2)
        else $error("plain block 0 outside shortcut");
    AST_AUTH_SEQ1: assert property ( // [R18]
        card_active && seq_r == SEQ_ONE |-> auth_uid == uid_hi)
        else $error("wrong authentication bytes");

    COV_SEQ1: cover property (st_r == ST_READY2 ##1 seq_r == SEQ_ONE
                              && card_active);
    COV_SEQ2: cover property (resp_r.kind == RESP_BLOCK0 && resp_r.valid
                              && !resp_r.encrypt);
    COV_PERSO: cover property (we_r);
    COV_RELOCK: cover property (locked_r && pend_r &&
                                pend_ans_r == `ANS_NAK);
    COV_FOUR: cover property (card_active && !variant_seven);
endmodule

// >>> logic/uid_select_map.svh
// constants for the identifier usage and selection logic
// Contract
// R1: identifier comes from block 0 of sector 0
// R2: four settings, factory setting number one
// R3: frame 40h, type, CRC; 4-bit answer
// R4: types 00h, 40h, 20h, 60h
// R5: configure only after sector 0 authentication
// R6: accepted configuration locks itself permanently
// R7: locked: no change, negative acknowledge
// R8: Ah acknowledges, any other nibble refuses
// R9: new setting acts after unselect or reset
// R10: answer no earlier than 71 us
// R11: request answer independent of setting
// R12: select acknowledge 08h when selection completes
// R13: sequence 1 needs level one then two
// R14: sequence 2 reads block 0 plain
// R15: other sequences: block 0 authenticated, encrypted
// R16: allowed sequences depend on setting
// R17: setting 2 random, setting 3 derived
// R18: authentication bytes depend on sequence
// R19: four-byte variant uses level one only
// R20: four-byte variant authenticates whole identifier
// R21: reader should configure once at personalisation
// R22: unknown type refused, nothing changes
`ifndef UID_SELECT_MAP_SVH
`define UID_SELECT_MAP_SVH
`define CMD_REQ        8'h26
`define CMD_WAKE       8'h52
`define CMD_SEL_ONE    8'h93
`define CMD_SEL_TWO    8'h95
`define ARG_ANTICOL    8'h20
`define ARG_SELECT     8'h70
`define CMD_HALT       8'h50
`define CMD_READ       8'h30
`define CMD_PERSO      8'h40
`define TYPE_DOUBLE    8'h00
`define TYPE_SHORTCUT  8'h40
`define TYPE_RANDOM    8'h20
`define TYPE_DERIVED   8'h60
`define CASCADE_TAG    8'h88
`define ANS_ACK        4'ha
`define ANS_NAK        4'h4
`define SAK_DONE       8'h08
`define SAK_MORE       8'h04
`define ATQA_SEVEN     16'h0044
`define ATQA_FOUR      16'h0004
`define CLK_PERIOD_NS  100
`define FDT_MIN_NS     71000
`define TIMEOUT_NS     10000000
`define FDT_CYC        ((`FDT_MIN_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`endif

// >>> logic/uid_select_pkg.sv
// types for the identifier usage and selection logic
package uid_select_pkg;
    typedef enum logic [1:0] {
        USAGE_DOUBLE_SIZE, USAGE_DOUBLE_SIZE_SHORTCUT,
        USAGE_RANDOM_SINGLE, USAGE_DERIVED_SINGLE
    } usage_t;
    typedef enum logic [2:0] {
        RESP_ATQA, RESP_UID, RESP_SAK, RESP_ACKNAK, RESP_BLOCK0
    } resp_kind_t;
    typedef enum logic [1:0] {SEQ_ONE, SEQ_TWO, SEQ_THREE} seq_t;
    typedef struct packed {
        logic       valid;
        logic [7:0] cmd;
        logic [7:0] arg;
        logic       crc_ok;
        logic [31:0] sel_uid;
    } rx_t;
    typedef struct packed {
        logic       valid;
        resp_kind_t kind;
        logic [31:0] data;
        logic       encrypt;
    } resp_t;
endpackage

// >>> test/reader_model.sv
// reader-side model that sends decoded frames and collects card answers
`timescale 1ns/1ps
module reader_model import uid_select_pkg::*; #(
    // shortened from the 10 ms reader timeout to keep the run brief
    parameter int WAIT_CYC = 800
) (
    // clock
    input  wire logic  sys_clk,
    // card side
    input  wire resp_t resp,
    output rx_t        rx
);
    initial rx = '0;

    // ------------------------------------------------------------
    // one frame, then a bounded wait for the answer
    // ------------------------------------------------------------
    task automatic xfer(input logic [7:0] c, a, input logic [31:0] s,
                        input logic k, output logic g, output resp_t r,
                        output int lat);
        int n;
        g = 1'b0;
        r = '0;
        lat = 0;
        @(posedge sys_clk);
        rx <= '{1'b1, c, a, k, s};
        @(posedge sys_clk);
        // released fields show the inverse, never a stale frame
        rx <= '{1'b0, ~c, ~a, 1'b0, ~s};
        for (n = 1; n <= WAIT_CYC && !g; n++) begin
            @(negedge sys_clk);
            if (resp.valid === 1'b1) begin
                g = 1'b1;
                r = resp;
                lat = n;
            end
        end
    endtask
endmodule

// >>> test/uid_select_tb_top.sv
// self-checking bench for the identifier usage and activation logic
`timescale 1ns/1ps
`include "uid_select_map.svh"
`define CHK(nm, e, s) begin compares++; if ((s) !== (e)) begin failures++; \
    $display("ERROR %s expected %0h seen %0h", nm, e, s); end end
module uid_select_tb_top import uid_select_pkg::*;;
    logic        sys_clk = 1'b0;
    logic        rst_n = 1'b0;
    rx_t         rx;
    logic        variant_seven = 1'b1;
    logic [55:0] uid_blk0 = '0;
    logic [31:0] rnd_id = '0;
    logic        auth_sec0_ok = 1'b0;
    usage_t      nv_setting = USAGE_DOUBLE_SIZE_SHORTCUT;
    logic        nv_locked = 1'b0;
    logic        nv_we;
    usage_t      nv_wdata;
    resp_t       resp;
    logic [31:0] auth_uid;
    logic        card_active;
    resp_t       lr;
    logic        g0;
    int          lat0;
    int          failures = 0;
    int          compares = 0;
    int          we_cnt = 0;
    int          we0;
    usage_t      we_val;
    logic [63:0] r64;
    logic [7:0]  bad;
    logic [7:0]  types [4] = '{`TYPE_DOUBLE, `TYPE_SHORTCUT,
                               `TYPE_RANDOM, `TYPE_DERIVED};

    always #50 sys_clk = ~sys_clk;

    uid_select uut (.sys_clk(sys_clk), .rst_n(rst_n), .rx(rx),
        .variant_seven(variant_seven), .uid_blk0(uid_blk0),
        .rnd_id(rnd_id), .auth_sec0_ok(auth_sec0_ok),
        .nv_setting(nv_setting), .nv_locked(nv_locked), .nv_we(nv_we),
        .nv_wdata(nv_wdata), .resp(resp), .auth_uid(auth_uid),
        .card_active(card_active));
    reader_model rdr (.sys_clk(sys_clk), .resp(resp), .rx(rx));

    // ------------------------------------------------------------
    // nonvolatile cell: a write also sets the lock
    // ------------------------------------------------------------
    always @(posedge sys_clk) begin
        if (nv_we === 1'b1) begin
            nv_setting <= nv_wdata;
            nv_locked <= 1'b1;
        end
    end
    always @(negedge sys_clk) begin
        if (nv_we === 1'b1) begin
            we_cnt = we_cnt + 1;
            we_val = nv_wdata;
        end
    end

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    task automatic complete_run();
        $display("compares %0d failures %0d", compares, failures);
        if (failures == 0 && compares > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    function automatic logic [31:0] cl1w(input usage_t s);
        case (s)
            USAGE_RANDOM_SINGLE:  return rnd_id;
            USAGE_DERIVED_SINGLE: return uid_blk0[31:0]
                                         ^ {8'h00, uid_blk0[55:32]};
            default:              return {uid_blk0[23:0], `CASCADE_TAG};
        endcase
    endfunction

    task automatic do_reset(input logic v, input usage_t s, input logic l);
        @(posedge sys_clk);
        r64 = {$urandom, $urandom};
        rst_n <= 1'b0;
        variant_seven <= v;
        nv_setting <= s;
        nv_locked <= l;
        auth_sec0_ok <= 1'b0;
        uid_blk0 <= r64[55:0];
        rnd_id <= $urandom;
        repeat (12) @(posedge sys_clk);
        rst_n <= 1'b1;
        repeat (2) @(posedge sys_clk);
    endtask

    task automatic tx(input logic [7:0] c, a, input logic [31:0] s,
                      input logic eg, input resp_kind_t ek,
                      input logic [31:0] ed, m);
        logic g;
        int lat;
        rdr.xfer(c, a, s, 1'b1, g, lr, lat);
        `CHK("answered", eg, g)
        if (eg && !g) complete_run();
        if (eg && g) begin
            `CHK("resp.kind", ek, lr.kind)
            `CHK("resp.data", ed & m, lr.data & m)
            // a personalisation answer shows one edge past the full frame delay, any other answer on the first edge
            `CHK("latency", (c == `CMD_PERSO) ? `FDT_CYC + 1 : 1, lat)
        end
    endtask

    task automatic set_auth(input logic v);
        @(posedge sys_clk) auth_sec0_ok <= v;
    endtask

    // sc picks the block 0 shortcut after level one
    task automatic act1(input usage_t s, input logic sc, input logic [7:0] wc);
        logic [31:0] w;
        logic ok;
        w = cl1w(s);
        ok = !(sc && s == USAGE_DOUBLE_SIZE);
        tx(wc, 8'h00, 32'h0, 1'b1, RESP_ATQA, `ATQA_SEVEN, 32'hffff);
        tx(`CMD_SEL_ONE, `ARG_ANTICOL, 32'h0, 1'b1, RESP_UID, w, '1);
        if (s > USAGE_DOUBLE_SIZE_SHORTCUT) begin
            tx(`CMD_SEL_ONE, `ARG_SELECT, w, 1'b1, RESP_SAK, `SAK_DONE, 8'hff);
        end else begin
            tx(`CMD_SEL_ONE, `ARG_SELECT, w, 1'b1, RESP_SAK, `SAK_MORE, 8'hff);
            if (sc) begin
                tx(`CMD_READ, 8'h00, 32'h0, ok, RESP_BLOCK0, 0, 0);
                if (ok) `CHK("encrypt", 1'b0, lr.encrypt)
            end else begin
                w = uid_blk0[55:24];
                tx(`CMD_SEL_TWO, `ARG_ANTICOL, 32'h0, 1'b1, RESP_UID, w, '1);
                tx(`CMD_SEL_TWO, `ARG_SELECT, w, 1'b1, RESP_SAK, `SAK_DONE, 8'hff);
            end
        end
        if (ok) begin
            `CHK("auth_uid", w, auth_uid)
            `CHK("card_active", 1'b1, card_active)
        end
    endtask

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        void'($urandom(32'h7395));
        for (int i = 0; i < 4; i++) begin
            do_reset(1'b1, USAGE_DOUBLE_SIZE_SHORTCUT, 1'b0);
            act1(USAGE_DOUBLE_SIZE_SHORTCUT, 1'b0, `CMD_REQ);
            tx(`CMD_READ, 8'h00, 32'h0, 1'b1, RESP_ACKNAK, `ANS_NAK, 4'hf);
            we0 = we_cnt;
            tx(`CMD_PERSO, types[i], 32'h0, 1'b1, RESP_ACKNAK, `ANS_NAK, 4'hf);
            set_auth(1'b1);
            tx(`CMD_READ, 8'h00, 32'h0, 1'b1, RESP_BLOCK0, 0, 0);
            `CHK("encrypt", 1'b1, lr.encrypt)
            bad = 8'($urandom) | 8'h01;
            tx(`CMD_PERSO, bad, 32'h0, 1'b1, RESP_ACKNAK, `ANS_NAK, 4'hf);
            `CHK("nv writes", we0, we_cnt)
            tx(`CMD_PERSO, types[i], 32'h0, 1'b1, RESP_ACKNAK, `ANS_ACK, 4'hf);
            `CHK("nv writes", we0 + 1, we_cnt)
            `CHK("nv_wdata", usage_t'(i), we_val)
            tx(`CMD_PERSO, types[i ^ 1], 32'h0, 1'b1, RESP_ACKNAK, `ANS_NAK, 4'hf);
            `CHK("nv writes", we0 + 1, we_cnt)
            tx(`CMD_HALT, 8'h00, 32'h0, 1'b0, RESP_ACKNAK, 0, 0);
            `CHK("card_active", 1'b0, card_active)
            tx(`CMD_REQ, 8'h00, 32'h0, 1'b0, RESP_ATQA, 0, 0);
            set_auth(1'b0);
            act1(usage_t'(i), 1'b0, `CMD_WAKE);
            if (i < 2) begin
                tx(`CMD_HALT, 8'h00, 32'h0, 1'b0, RESP_ACKNAK, 0, 0);
                act1(usage_t'(i), 1'b1, `CMD_WAKE);
            end
        end
        // locked cell survives a field reset
        do_reset(1'b1, nv_setting, nv_locked);
        act1(USAGE_DERIVED_SINGLE, 1'b0, `CMD_REQ);
        set_auth(1'b1);
        tx(`CMD_PERSO, `TYPE_DOUBLE, 32'h0, 1'b1, RESP_ACKNAK, `ANS_NAK, 4'hf);
        // four-byte part
        do_reset(1'b0, USAGE_DOUBLE_SIZE_SHORTCUT, 1'b0);
        rdr.xfer(`CMD_REQ, 8'h00, 32'h0, 1'b0, g0, lr, lat0);
        `CHK("bad crc answered", 1'b0, g0)
        tx(`CMD_REQ, 8'h00, 32'h0, 1'b1, RESP_ATQA, `ATQA_FOUR, 32'hffff);
        tx(`CMD_SEL_ONE, `ARG_ANTICOL, 32'h0, 1'b1, RESP_UID, uid_blk0[31:0], '1);
        tx(`CMD_SEL_ONE, `ARG_SELECT, uid_blk0[31:0], 1'b1, RESP_SAK, `SAK_DONE, 8'hff);
        `CHK("auth_uid", uid_blk0[31:0], auth_uid)
        `CHK("card_active", 1'b1, card_active)
        tx(`CMD_SEL_TWO, `ARG_ANTICOL, 32'h0, 1'b0, RESP_UID, 0, 0);
        set_auth(1'b1);
        tx(`CMD_PERSO, `TYPE_RANDOM, 32'h0, 1'b1, RESP_ACKNAK, `ANS_NAK, 4'hf);
        complete_run();
    end
endmodule
